// [iwt_pkg.sv]
// Shared constants for the wakeup, timer and message link ends
package iwt_pkg;
   // ---------------------------------------------------------------
   // Clock and wake sequence timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int INIT_WAIT_MS = 10;
   localparam int START_WAIT_US = 200;
   // Least times, rounded up to whole cycles
   localparam int INIT_WAIT_CYC =
      (INIT_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_WAIT_CYC =
      (START_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_CNT_W = 19;

   // ---------------------------------------------------------------
   // Message layout: type in the top two bits, payload below
   // ---------------------------------------------------------------
   localparam int MSG_W = 8;
   localparam int MSG_TYPE_HI = 7;
   localparam int MSG_TYPE_LO = 6;
   localparam logic [1:0] MSG_SOFT_INIT = 2'h1;
   localparam logic [1:0] MSG_WAKE_START = 2'h2;
   localparam logic [7:0] MSG_INIT_WORD = 8'h40;
   localparam logic [7:0] MSG_START_WORD = 8'h80;

   // ---------------------------------------------------------------
   // Timer access port: selects, size code, reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_INIT_CNT = 2'h0;
   localparam logic [1:0] SEL_CUR_CNT = 2'h1;
   localparam logic [1:0] SEL_DIVIDE = 2'h2;
   localparam logic [1:0] SEL_MODE = 2'h3;
   localparam logic [1:0] ACC_SIZE_32 = 2'h2;
   localparam logic [31:0] TMR_CNT_RST = 32'h0000_0000;
   localparam logic [2:0] TMR_DIV_RST = 3'h0;
   localparam int MODE_PERIODIC_BIT = 0;
endpackage

// [iwt_link_if.sv]
// Interrupt message link between the two ends, one lane per direction
`timescale 1ns/10ps
interface iwt_link_if;
   // Boot end to device end
   logic h2d_vld;
   logic [7:0] h2d_msg;
   logic h2d_chk;
   logic h2d_ack;
   logic h2d_err;
   // Device end to boot end
   logic d2h_vld;
   logic [7:0] d2h_msg;
   logic d2h_chk;
   logic d2h_ack;
   logic d2h_err;

   modport dev (
      input h2d_vld, h2d_msg, h2d_chk, d2h_ack, d2h_err,
      output h2d_ack, h2d_err, d2h_vld, d2h_msg, d2h_chk
   );
   modport boot (
      output h2d_vld, h2d_msg, h2d_chk, d2h_ack, d2h_err,
      input h2d_ack, h2d_err, d2h_vld, d2h_msg, d2h_chk
   );
endinterface

// [iwt_dev_end.sv]
// Device end: wake control, timer, access checks and message link
// Operation
// - Secondary sleeps after reset or init until start
// - Secondary halts instead of fetching reset vector
// - Init pin toggle equals init message
// - Init while halted stays pending until start
// - After wake, act on init, ignore starts
// - Primary drops every start with no effect
// - Boot end sends init, waits 10 ms
// - Then two starts, 200 us each, unless legacy
// - Boot end confirms secondary executing afterwards
// - Shutdown uses init messages only
// - Equal ticks, last tick one timer clock
// - Short last tick also in one-shot
// - Current count loads clock after initial write
// - Accept aligned 32-bit reads and writes
// - Software avoids 8/16-bit writes
// - No bus lock toward controller space
// - Resend a message answered with checksum error
`timescale 1ns/10ps
module iwt_dev_end (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   iwt_link_if.dev lnk,
   input wire logic upgrade_i,
   input wire logic init_pin_i,
   input wire logic lock_req_i,
   input wire logic lock_ctrl_space_i,
   input wire logic acc_req_i,
   input wire logic acc_we_i,
   input wire logic [1:0] acc_size_i,
   input wire logic [3:0] acc_addr_i,
   input wire logic [31:0] acc_wdata_i,
   output logic acc_ack_o,
   output logic acc_err_o,
   output logic [31:0] acc_rdata_o,
   input wire logic send_valid_i,
   input wire logic [7:0] send_msg_i,
   input wire logic send_bad_chk_i,
   output logic send_ready_o,
   output logic running_o,
   output logic soft_init_o,
   output logic timer_evt_o,
   output logic bus_lock_o
);
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HALT = 2'b01,
      ST_BOOT = 2'b10
   } iwt_wake_t;

   // ---------------------------------------------------------------
   // Link domain
   // ---------------------------------------------------------------
   logic lrst_s1, lrst_s2, lce_s1, lce_s2;
   logic rack_s1, rack_s2, treq_s1, treq_s2;
   logic rx_got, rx_req, tx_done, tx_retry;
   logic [7:0] rx_hold;
   logic rx_busy, tx_pend;
   // Core side handshake state read by the link side
   logic rx_ack, tx_req;
   logic [8:0] tx_data;

   // Reset, enable and handshake synchronisers
   always_ff @(posedge link_clk_i) begin
      lrst_s1 <= reset_n_i;
      lrst_s2 <= lrst_s1;
      lce_s1 <= ce_i;
      lce_s2 <= lce_s1;
      rack_s1 <= rx_ack;
      rack_s2 <= rack_s1;
      treq_s1 <= tx_req;
      treq_s2 <= treq_s1;
   end

   assign rx_busy = rx_req != rack_s2;
   assign tx_pend = treq_s2 != tx_done;

   // Receiver: one answer per message, held off while core is busy
   always_ff @(posedge link_clk_i) begin
      if (!lrst_s2) begin
         rx_got <= 1'b0;
         rx_req <= 1'b0;
         rx_hold <= 8'h00;
         lnk.h2d_ack <= 1'b0;
         lnk.h2d_err <= 1'b0;
      end else if (lce_s2) begin
         lnk.h2d_ack <= 1'b0;
         lnk.h2d_err <= 1'b0;
         if (!lnk.h2d_vld) begin
            rx_got <= 1'b0;
         end else if (!rx_got && !rx_busy) begin
            rx_got <= 1'b1;
            if ((^lnk.h2d_msg) == lnk.h2d_chk) begin
               lnk.h2d_ack <= 1'b1;
               rx_hold <= lnk.h2d_msg;
               rx_req <= ~rx_req;
            end else begin
               lnk.h2d_err <= 1'b1; // Sender must resend
            end
         end
      end
   end

   // Sender: drops valid one cycle, then resends after an error
   always_ff @(posedge link_clk_i) begin
      if (!lrst_s2) begin
         lnk.d2h_vld <= 1'b0;
         lnk.d2h_msg <= 8'h00;
         lnk.d2h_chk <= 1'b0;
         tx_done <= 1'b0;
         tx_retry <= 1'b0;
      end else if (lce_s2) begin
         if (lnk.d2h_vld) begin
            if (lnk.d2h_ack) begin
               lnk.d2h_vld <= 1'b0;
               tx_done <= treq_s2;
               tx_retry <= 1'b0;
            end else if (lnk.d2h_err) begin
               lnk.d2h_vld <= 1'b0;
            end
         end else if (tx_pend) begin
            lnk.d2h_vld <= 1'b1;
            lnk.d2h_msg <= tx_data[7:0];
            // Forced bad checksum only on the first attempt
            lnk.d2h_chk <= (^tx_data[7:0]) ^ (tx_data[8] & ~tx_retry);
            tx_retry <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Core domain: crossings and pin inputs
   // ---------------------------------------------------------------
   logic rreq_s1, rreq_s2, rreq_s3, tdone_s1, tdone_s2;
   logic up_s1, up_s2, ini_s1, ini_s2, ini_s3, role_sec;
   logic rx_evt, msg_init, msg_start, init_evt;

   // Two flops ahead of any logic on every foreign input
   always_ff @(posedge clk_i) begin
      rreq_s1 <= rx_req;
      rreq_s2 <= rreq_s1;
      tdone_s1 <= tx_done;
      tdone_s2 <= tdone_s1;
      up_s1 <= upgrade_i;
      up_s2 <= up_s1;
      ini_s1 <= init_pin_i;
      ini_s2 <= ini_s1;
   end

   assign rx_evt = rreq_s2 ^ rreq_s3;
   assign msg_init = rx_evt &&
      rx_hold[iwt_pkg::MSG_TYPE_HI:iwt_pkg::MSG_TYPE_LO] ==
      iwt_pkg::MSG_SOFT_INIT;
   assign msg_start = rx_evt &&
      rx_hold[iwt_pkg::MSG_TYPE_HI:iwt_pkg::MSG_TYPE_LO] ==
      iwt_pkg::MSG_WAKE_START;
   assign init_evt = msg_init || (ini_s2 && !ini_s3);

   // Edge history, role strap caught while reset is held
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rreq_s3 <= 1'b0;
         rx_ack <= 1'b0;
         ini_s3 <= 1'b0;
         role_sec <= up_s2;
      end else if (ce_i) begin
         rreq_s3 <= rreq_s2;
         rx_ack <= rreq_s2; // Frees the receiver once consumed
         ini_s3 <= ini_s2;
      end
   end

   // Send request handshake toward the link sender
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tx_req <= 1'b0;
         tx_data <= 9'h000;
         send_ready_o <= 1'b0;
      end else if (ce_i) begin
         if (send_ready_o && send_valid_i) begin
            tx_req <= ~tx_req;
            tx_data <= {send_bad_chk_i, send_msg_i};
            send_ready_o <= 1'b0;
         end else begin
            send_ready_o <= tx_req == tdone_s2;
         end
      end
   end

   // ---------------------------------------------------------------
   // Wake control
   // ---------------------------------------------------------------
   iwt_wake_t wake_st;
   logic init_pend;

   // Starts only land while halted, and only a secondary halts
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wake_st <= ST_BOOT;
         init_pend <= 1'b0;
         running_o <= 1'b0;
         soft_init_o <= 1'b0;
      end else if (ce_i) begin
         soft_init_o <= 1'b0;
         case (wake_st)
            ST_BOOT: begin
               wake_st <= role_sec ? ST_HALT : ST_RUN;
               running_o <= !role_sec;
            end
            ST_HALT: begin
               if (msg_start) begin
                  wake_st <= ST_RUN;
                  running_o <= 1'b1;
                  soft_init_o <= init_pend || init_evt;
                  init_pend <= 1'b0;
               end else if (init_evt) begin
                  init_pend <= 1'b1;
               end
            end
            ST_RUN: begin
               // Starts fall through untouched here
               if (init_evt && role_sec) begin
                  wake_st <= ST_HALT;
                  running_o <= 1'b0;
               end else if (init_evt) begin
                  soft_init_o <= 1'b1;
               end
            end
            default: begin
               wake_st <= ST_BOOT;
               running_o <= 1'b0;
            end
         endcase
      end
   end

   // Locked cycles into controller space never lock the bus
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         bus_lock_o <= 1'b0;
      end else if (ce_i) begin
         bus_lock_o <= lock_req_i && !lock_ctrl_space_i;
      end
   end

   // ---------------------------------------------------------------
   // Timer and its access port
   // ---------------------------------------------------------------
   logic [31:0] init_cnt, cur_cnt;
   logic [2:0] div_code;
   logic periodic, load_pend, tmr_on;
   logic [6:0] presc;
   logic [7:0] div_full, div_lim;
   logic acc_ok, dec;

   assign acc_ok = acc_size_i == iwt_pkg::ACC_SIZE_32 &&
      acc_addr_i[1:0] == 2'h0;
   assign div_full = 8'h01 << div_code;
   assign div_lim = div_full - 8'h01;
   // Final count step takes one timer clock whatever the divisor
   assign dec = tmr_on && (presc == div_lim[6:0] ||
      cur_cnt == 32'h0000_0001);

   // Access answers; narrow or unaligned cycles are refused
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_ack_o <= 1'b0;
         acc_err_o <= 1'b0;
         acc_rdata_o <= 32'h0000_0000;
         init_cnt <= iwt_pkg::TMR_CNT_RST;
         div_code <= iwt_pkg::TMR_DIV_RST;
         periodic <= 1'b0;
      end else if (ce_i) begin
         acc_ack_o <= acc_req_i;
         acc_err_o <= acc_req_i && !acc_ok;
         if (acc_req_i && acc_ok && acc_we_i) begin
            case (acc_addr_i[3:2])
               iwt_pkg::SEL_INIT_CNT: init_cnt <= acc_wdata_i;
               iwt_pkg::SEL_DIVIDE: div_code <= acc_wdata_i[2:0];
               iwt_pkg::SEL_MODE:
                  periodic <= acc_wdata_i[iwt_pkg::MODE_PERIODIC_BIT];
               default: periodic <= periodic; // Count is read-only
            endcase
         end
         if (acc_req_i && acc_ok && !acc_we_i) begin
            case (acc_addr_i[3:2])
               iwt_pkg::SEL_INIT_CNT: acc_rdata_o <= init_cnt;
               iwt_pkg::SEL_CUR_CNT: acc_rdata_o <= cur_cnt;
               iwt_pkg::SEL_DIVIDE: acc_rdata_o <= {29'h0, div_code};
               default: acc_rdata_o <= {31'h0, periodic};
            endcase
         end else begin
            acc_rdata_o <= 32'h0000_0000;
         end
      end
   end

   // Countdown; a new initial count restarts it one clock later
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cur_cnt <= iwt_pkg::TMR_CNT_RST;
         load_pend <= 1'b0;
         tmr_on <= 1'b0;
         presc <= 7'h00;
         timer_evt_o <= 1'b0;
      end else if (ce_i) begin
         timer_evt_o <= 1'b0;
         load_pend <= acc_req_i && acc_ok && acc_we_i &&
            acc_addr_i[3:2] == iwt_pkg::SEL_INIT_CNT;
         if (load_pend) begin
            cur_cnt <= init_cnt;
            tmr_on <= init_cnt != 32'h0000_0000;
            presc <= 7'h00;
         end else if (dec) begin
            presc <= 7'h00;
            if (cur_cnt == 32'h0000_0001) begin
               timer_evt_o <= 1'b1;
               cur_cnt <= periodic ? init_cnt : 32'h0000_0000;
               tmr_on <= periodic;
            end else begin
               cur_cnt <= cur_cnt - 32'h0000_0001;
            end
         end else if (tmr_on) begin
            presc <= presc + 7'h01;
         end
      end
   end
endmodule

// [iwt_boot_end.sv]
// Boot end: wake and shutdown sequencer and its message link side
`timescale 1ns/10ps
module iwt_boot_end #(
   parameter int INIT_WAIT_CYC = iwt_pkg::INIT_WAIT_CYC,
   parameter int START_WAIT_CYC = iwt_pkg::START_WAIT_CYC
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   iwt_link_if.boot lnk,
   input wire logic wake_i,
   input wire logic shutdown_i,
   input wire logic legacy_i,
   input wire logic inject_err_i,
   input wire logic alive_i,
   output logic busy_o,
   output logic done_o,
   output logic rx_valid_o,
   output logic [7:0] rx_msg_o
);
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000,
      SQ_INIT_W = 3'b001,
      SQ_ST1_W = 3'b010,
      SQ_ST2_W = 3'b011,
      SQ_VERIFY = 3'b100,
      SQ_SHUT_W = 3'b101
   } iwt_seq_t;

   // ---------------------------------------------------------------
   // Link domain
   // ---------------------------------------------------------------
   logic lrst_s1, lrst_s2, lce_s1, lce_s2;
   logic rack_s1, rack_s2, treq_s1, treq_s2;
   logic rx_got, rx_req, tx_done, tx_retry, rx_busy, tx_pend;
   logic [7:0] rx_hold;
   logic rx_ack, tx_req;
   logic [8:0] tx_data;

   // Reset, enable and handshake synchronisers
   always_ff @(posedge link_clk_i) begin
      lrst_s1 <= reset_n_i;
      lrst_s2 <= lrst_s1;
      lce_s1 <= ce_i;
      lce_s2 <= lce_s1;
      rack_s1 <= rx_ack;
      rack_s2 <= rack_s1;
      treq_s1 <= tx_req;
      treq_s2 <= treq_s1;
   end

   assign rx_busy = rx_req != rack_s2;
   assign tx_pend = treq_s2 != tx_done;

   // Sender toward the device, resending after a checksum error
   always_ff @(posedge link_clk_i) begin
      if (!lrst_s2) begin
         lnk.h2d_vld <= 1'b0;
         lnk.h2d_msg <= 8'h00;
         lnk.h2d_chk <= 1'b0;
         tx_done <= 1'b0;
         tx_retry <= 1'b0;
      end else if (lce_s2) begin
         if (lnk.h2d_vld) begin
            if (lnk.h2d_ack) begin
               lnk.h2d_vld <= 1'b0;
               tx_done <= treq_s2;
               tx_retry <= 1'b0;
            end else if (lnk.h2d_err) begin
               lnk.h2d_vld <= 1'b0;
            end
         end else if (tx_pend) begin
            lnk.h2d_vld <= 1'b1;
            lnk.h2d_msg <= tx_data[7:0];
            lnk.h2d_chk <= (^tx_data[7:0]) ^ (tx_data[8] & ~tx_retry);
            tx_retry <= 1'b1;
         end
      end
   end

   // Receiver of device messages
   always_ff @(posedge link_clk_i) begin
      if (!lrst_s2) begin
         rx_got <= 1'b0;
         rx_req <= 1'b0;
         rx_hold <= 8'h00;
         lnk.d2h_ack <= 1'b0;
         lnk.d2h_err <= 1'b0;
      end else if (lce_s2) begin
         lnk.d2h_ack <= 1'b0;
         lnk.d2h_err <= 1'b0;
         if (!lnk.d2h_vld) begin
            rx_got <= 1'b0;
         end else if (!rx_got && !rx_busy) begin
            rx_got <= 1'b1;
            if ((^lnk.d2h_msg) == lnk.d2h_chk) begin
               lnk.d2h_ack <= 1'b1;
               rx_hold <= lnk.d2h_msg;
               rx_req <= ~rx_req;
            end else begin
               lnk.d2h_err <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Core domain
   // ---------------------------------------------------------------
   logic rreq_s1, rreq_s2, rreq_s3, tdone_s1, tdone_s2;
   logic alv_s1, alv_s2, tx_idle;
   logic [iwt_pkg::WAIT_CNT_W-1:0] wait_cnt;
   iwt_seq_t seq_st;

   // Two flops ahead of any logic on every foreign input
   always_ff @(posedge clk_i) begin
      rreq_s1 <= rx_req;
      rreq_s2 <= rreq_s1;
      tdone_s1 <= tx_done;
      tdone_s2 <= tdone_s1;
      alv_s1 <= alive_i;
      alv_s2 <= alv_s1;
   end

   assign tx_idle = tx_req == tdone_s2;

   // Received messages handed out as a one-cycle strobe
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rreq_s3 <= 1'b0;
         rx_ack <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_msg_o <= 8'h00;
      end else if (ce_i) begin
         rreq_s3 <= rreq_s2;
         rx_ack <= rreq_s2;
         rx_valid_o <= rreq_s2 ^ rreq_s3;
         rx_msg_o <= rx_hold;
      end
   end

   // Delays run only once the message is delivered, so a resend
   // cannot eat into the wait
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         seq_st <= SQ_IDLE;
         wait_cnt <= '0;
         tx_req <= 1'b0;
         tx_data <= 9'h000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (seq_st != SQ_IDLE && tx_idle && wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
         end
         case (seq_st)
            SQ_IDLE: begin
               if (wake_i || shutdown_i) begin
                  tx_req <= ~tx_req; // Init first
                  tx_data <= {inject_err_i, iwt_pkg::MSG_INIT_WORD};
                  wait_cnt <= INIT_WAIT_CYC[iwt_pkg::WAIT_CNT_W-1:0];
                  seq_st <= wake_i ? SQ_INIT_W : SQ_SHUT_W;
                  busy_o <= 1'b1;
               end
            end
            SQ_INIT_W: begin
               if (tx_idle && wait_cnt == '0 && legacy_i) begin
                  seq_st <= SQ_VERIFY;
               end else if (tx_idle && wait_cnt == '0) begin
                  tx_req <= ~tx_req;
                  tx_data <= {1'b0, iwt_pkg::MSG_START_WORD};
                  wait_cnt <= START_WAIT_CYC[iwt_pkg::WAIT_CNT_W-1:0];
                  seq_st <= SQ_ST1_W;
               end
            end
            SQ_ST1_W: begin
               if (tx_idle && wait_cnt == '0) begin
                  tx_req <= ~tx_req;
                  tx_data <= {1'b0, iwt_pkg::MSG_START_WORD};
                  wait_cnt <= START_WAIT_CYC[iwt_pkg::WAIT_CNT_W-1:0];
                  seq_st <= SQ_ST2_W;
               end
            end
            SQ_ST2_W: begin
               if (tx_idle && wait_cnt == '0) begin
                  seq_st <= SQ_VERIFY;
               end
            end
            SQ_VERIFY: begin
               if (alv_s2) begin
                  done_o <= 1'b1;
                  busy_o <= 1'b0;
                  seq_st <= SQ_IDLE;
               end
            end
            SQ_SHUT_W: begin
               if (tx_idle) begin
                  busy_o <= 1'b0; // No start follows
                  seq_st <= SQ_IDLE;
               end
            end
            default: begin
               seq_st <= SQ_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end
endmodule

// [iwt_link_chk.sv]
// Link lane checks between the boot end and the device end
`timescale 1ns/10ps
module iwt_link_chk (
   input wire logic link_clk_i,
   input wire logic reset_n_i,
   input wire logic h2d_vld,
   input wire logic [7:0] h2d_msg,
   input wire logic h2d_chk,
   input wire logic h2d_ack,
   input wire logic h2d_err,
   input wire logic d2h_vld,
   input wire logic [7:0] d2h_msg,
   input wire logic d2h_chk,
   input wire logic d2h_ack,
   input wire logic d2h_err
);
   // -------------------------------------------------------------
   // Lane handshake, parity and retry
   // -------------------------------------------------------------
   default clocking cb @(posedge link_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_ack_has_vld: assert property (h2d_ack |-> h2d_vld)
      else $error("ack without valid");
   chk_good_acked: assert property (h2d_ack |-> h2d_chk == ^h2d_msg)
      else $error("bad parity acked");
   chk_bad_errored: assert property (h2d_err |-> h2d_chk != ^h2d_msg)
      else $error("good parity refused");
   chk_err_resends: assert property (h2d_err |=> !h2d_vld ##[1:8]
      (h2d_vld && h2d_chk == ^h2d_msg)) else $error("no resend");
   chk_vld_holds: assert property (h2d_vld && !h2d_ack && !h2d_err
      |=> h2d_vld && $stable(h2d_msg)) else $error("valid dropped");
   chk_ack_err_excl: assert property (!(d2h_ack && d2h_err))
      else $error("ack and err together");
   chk_ack_one_cyc: assert property (d2h_ack |=> !d2h_ack)
      else $error("ack longer than one cycle");
   chk_dev_ack_vld: assert property (d2h_ack |-> d2h_vld)
      else $error("device lane ack without valid");
   chk_boot_types: assert property (h2d_vld |->
      h2d_msg[7:6] inside {2'h1, 2'h2}) else $error("unknown type");
endmodule

// [ipi_wakeup_and_timer_tb.sv]
// Self-checking bench joining the boot end and the device end
`timescale 1ns/10ps
module ipi_wakeup_and_timer_tb;
   typedef struct packed {
      logic we;
      logic [1:0] sz;
      logic [3:0] ad;
      logic [31:0] wd;
      logic er;
      logic [31:0] ex;
   } iwt_row_t;
   iwt_row_t rows [9];
   logic clk_i = 0, link_clk = 0, reset_n = 0, upgrade = 1, init_pin = 0;
   logic space = 0, req = 0, we = 0, sv = 0, bad = 1, wake = 0, shut = 0;
   logic inj = 0, ack, err, sr, run, si, evt, lock, busy, done, rxv;
   logic lk = 1, leg = 0;
   logic [1:0] sz = 0;
   logic [3:0] ad = 0;
   logic [31:0] wd = 0, rd;
   logic [7:0] rxm;
   int mismatches = 0, num_checks = 0, starts = 0, n, sis = 0;
   time t_init = 0, t_start = 0;

   iwt_link_if lnk ();
   iwt_dev_end i_iwt_dev_end (.clk_i(clk_i), .reset_n_i(reset_n),
      .ce_i(1'b1), .link_clk_i(link_clk), .lnk(lnk.dev),
      .upgrade_i(upgrade), .init_pin_i(init_pin), .lock_req_i(lk),
      .lock_ctrl_space_i(space), .acc_req_i(req), .acc_we_i(we),
      .acc_size_i(sz), .acc_addr_i(ad), .acc_wdata_i(wd), .acc_ack_o(ack),
      .acc_err_o(err), .acc_rdata_o(rd), .send_valid_i(sv),
      .send_msg_i(8'h3C), .send_bad_chk_i(bad), .send_ready_o(sr),
      .running_o(run), .soft_init_o(si), .timer_evt_o(evt),
      .bus_lock_o(lock));
   // Short waits keep the run brief
   iwt_boot_end #(.INIT_WAIT_CYC(50), .START_WAIT_CYC(20)) i_iwt_boot_end (
      .clk_i(clk_i), .reset_n_i(reset_n), .ce_i(1'b1), .link_clk_i(link_clk),
      .lnk(lnk.boot), .wake_i(wake), .shutdown_i(shut), .legacy_i(leg),
      .inject_err_i(inj), .alive_i(run), .busy_o(busy), .done_o(done),
      .rx_valid_o(rxv), .rx_msg_o(rxm));
   iwt_link_chk i_iwt_link_chk (.link_clk_i(link_clk), .reset_n_i(reset_n),
      .h2d_vld(lnk.h2d_vld), .h2d_msg(lnk.h2d_msg), .h2d_chk(lnk.h2d_chk),
      .h2d_ack(lnk.h2d_ack), .h2d_err(lnk.h2d_err), .d2h_vld(lnk.d2h_vld),
      .d2h_msg(lnk.d2h_msg), .d2h_chk(lnk.d2h_chk), .d2h_ack(lnk.d2h_ack),
      .d2h_err(lnk.d2h_err));

   // Core clock and an unrelated link clock
   always #12.5 clk_i = ~clk_i;
   always #16 link_clk = ~link_clk;

   // Stamp delivered messages on the boot lane
   always @(posedge link_clk) begin
      if (lnk.h2d_ack && lnk.h2d_msg[7:6] == 2'h2) begin
         if (starts == 0)
            t_start = $time;
         starts++;
      end else if (lnk.h2d_ack)
         t_init = $time;
   end

   // Count soft init pulses from the device end
   always @(posedge clk_i) begin
      if (si === 1'b1)
         sis++;
   end

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Bounded wait; a run-out counts as a mismatch
   task automatic wait_for(ref logic s, input int lim);
      int k;
      k = 0;
      while (s !== 1'b1 && k < lim) begin
         @(negedge clk_i);
         k++;
      end
      if (k == lim)
         mismatches++;
   endtask

   task automatic rst(input logic up);
      upgrade = up;
      reset_n = 0;
      repeat (12) @(negedge clk_i);
      reset_n = 1;
      repeat (6) @(negedge clk_i);
   endtask

   task automatic acc(input iwt_row_t r);
      {we, sz, ad, wd} = {r.we, r.sz, r.ad, r.wd};
      req = 1;
      @(negedge clk_i);
      req = 0;
      chk(ack, 1);
      chk(err, r.er);
      if (!r.we)
         chk(rd, r.ex);
      @(negedge clk_i); // Request rests low one cycle between calls
   endtask

   // Level held until the sequencer reports busy
   task automatic kick(ref logic s);
      s = 1;
      wait_for(busy, 20);
      s = 0;
   endtask

   task automatic give_verdict;
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Cut a hung run short
   initial begin
      #500000;
      mismatches++;
      give_verdict;
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      rows = '{'{1, 2'h2, 4'h8, 32'h7, 0, 0}, '{1, 2'h2, 4'h0, 32'h100, 0, 0},
         '{1, 2'h2, 4'hC, 32'h0, 0, 0}, '{0, 2'h2, 4'h4, 32'h0, 0, 32'h100},
         '{0, 2'h2, 4'h0, 32'h0, 0, 32'h100}, '{1, 2'h0, 4'h0, 32'hFF, 1, 0},
         '{0, 2'h2, 4'h0, 32'h0, 0, 32'h100}, '{0, 2'h2, 4'h2, 32'h0, 1, 0},
         '{1, 2'h1, 4'h8, 32'h3, 1, 0}};
      rst(1'b1);
      chk(run, 0);
      for (int i = 0; i < 9; i++) begin
         {lk, space} = i[1:0];
         acc(rows[i]);
         chk(lock, lk && !space);
      end
      // Periodic, divide by two, count of three; whole words
      acc('{1, 2'h2, 4'hC, 32'h1, 0, 0});
      acc('{1, 2'h2, 4'h8, 32'h1, 0, 0});
      acc('{1, 2'h2, 4'h0, 32'h3, 0, 0});
      wait_for(evt, 64);
      @(negedge clk_i);
      for (n = 1; evt !== 1'b1 && n < 64; n++)
         @(negedge clk_i);
      chk(n, 5);
      acc('{1, 2'h2, 4'hC, 32'h0, 0, 0});
      acc('{1, 2'h2, 4'h0, 32'h3, 0, 0});
      n = 0;
      repeat (40) begin
         @(negedge clk_i);
         n += evt;
      end
      chk(n, 1);
      acc('{1, 2'h2, 4'h0, 32'h0, 0, 0});
      // Wake with a spoiled first init
      inj = 1;
      kick(wake);
      repeat (40) @(negedge clk_i);
      chk(run, 0);
      wait_for(done, 3000);
      inj = 0;
      chk(run, 1);
      chk(starts, 2);
      chk(t_start - t_init >= 1250, 1);
      chk(sis, 1);
      kick(shut);
      repeat (200) @(negedge clk_i);
      chk(run, 0);
      kick(wake);
      wait_for(done, 3000);
      init_pin = 1;
      repeat (6) @(negedge clk_i);
      init_pin = 0;
      repeat (10) @(negedge clk_i);
      chk(run, 0);
      // Device to boot message, first try spoiled
      wait_for(sr, 40);
      sv = 1;
      @(negedge clk_i);
      sv = 0;
      wait_for(rxv, 200);
      bad = 0;
      chk(rxm, 8'h3C);
      rst(1'b0);
      starts = 0;
      kick(wake);
      repeat (40) @(negedge clk_i);
      chk(run, 1);
      wait_for(done, 3000);
      chk(run, 1);
      chk(starts, 2);
      // Legacy target: init only, no starts
      leg = 1;
      starts = 0;
      kick(wake);
      wait_for(done, 3000);
      chk(starts, 0);
      chk(run, 1);
      chk(sis, 4);
      give_verdict;
   end
endmodule
